// >>> logic/pwsm_consts.svh
// offsets, field positions and reset values of the pwm submodule back end
`ifndef PWSM_CONSTS_SVH
`define PWSM_CONSTS_SVH
// register byte offsets
`define PWSM_OFS_FRACA 8'h00
`define PWSM_OFS_FRACB 8'h04
`define PWSM_OFS_TRIG  8'h08
`define PWSM_OFS_OUTC  8'h0c
`define PWSM_OFS_CAP   8'h10
`define PWSM_OFS_DMA   8'h1c
`define PWSM_OFS_FMAP  8'h20
`define PWSM_OFS_STS   8'h24
`define PWSM_OFS_FIFO  8'h28
// fine delay fields
`define PWSM_F1_LSB    0
`define PWSM_F2_LSB    8
`define PWSM_F3_LSB    16
`define PWSM_F4_LSB    24
`define PWSM_F5_LSB    0
`define PWSM_FE1_BIT   8
`define PWSM_FE23_BIT  9
`define PWSM_FE45_BIT  10
// trigger fields
`define PWSM_PS_BIT    8
`define PWSM_MUX0_LSB  16
`define PWSM_MUX1_LSB  20
// output control fields
`define PWSM_INV_LSB   0
`define PWSM_MASK_LSB  4
`define PWSM_OEN_LSB   8
`define PWSM_FST_LSB   12
`define PWSM_SWUP_BIT  16
`define PWSM_XSRC_BIT  18
// capture control fields
`define PWSM_EN_BIT    0
`define PWSM_SRC_BIT   1
`define PWSM_ESEL_LSB  2
`define PWSM_OS_BIT    6
`define PWSM_WM_LSB    8
`define PWSM_FCNT_LSB  12
`define PWSM_ECMP_LSB  16
`define PWSM_FPER_LSB  24
// dma fields
`define PWSM_WDMA_BIT  0
`define PWSM_CDMA_BIT  1
`define PWSM_CSRC_BIT  2
`define PWSM_RDMA_LSB  4
// fault map and status fields
`define PWSM_AUTO_BIT  24
`define PWSM_SAFE_BIT  25
`define PWSM_CF_LSB    1
`define PWSM_FFLG_LSB  8
`define PWSM_FPIN_LSB  16
// reset value of every register
`define PWSM_RST_WORD  32'h0000_0000
`endif

// >>> logic/pwsm_pkg.sv
// types of the pwm submodule back end
package pwsm_pkg;
  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_RISE = 2'h2,
    EDGE_BOTH = 2'h3
  } pwsm_edge_t;
  typedef struct packed {
    logic [4:0] x;
    logic [4:0] a;
    logic [4:0] b;
  } pwsm_fdly_t;
  typedef struct packed {
    logic [7:0]      fper;
    logic [7:0]      ecmp;
    logic [2:0]      fcnt;
    logic [1:0]      wm;
    logic            oneshot;
    pwsm_edge_t [1:0] esel;
    logic            src;
    logic            en;
  } pwsm_capcfg_t;
endpackage

// >>> logic/pwsm_filt.sv
// capture input synchroniser, glitch filter and edge detector
`timescale 1ns/1ps
module pwsm_filt (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       din,
  input  wire logic [7:0] per,
  input  wire logic [2:0] cnt,
  output logic            rise,
  output logic            fall
);
  logic       s1_ff, s2_ff, q_ff, dq_ff, nxt_q;
  logic [7:0] pc_ff, nxt_pc;
  logic [2:0] mc_ff, nxt_mc;
  logic       tick;

  // sample tick, mismatch count and filtered level
  always_comb begin
    tick   = (pc_ff == per - 8'h01);
    nxt_pc = tick ? 8'h00 : pc_ff + 8'h01;
    nxt_q  = q_ff;
    nxt_mc = mc_ff;
    if (per == 8'h00) begin
      nxt_q  = s2_ff;
      nxt_mc = 3'h0;
      nxt_pc = 8'h00;
    end else if (tick) begin
      if (s2_ff == q_ff) begin
        nxt_mc = 3'h0;
      end else if (mc_ff == cnt) begin
        nxt_q  = s2_ff;
        nxt_mc = 3'h0;
      end else begin
        nxt_mc = mc_ff + 3'h1;
      end
    end
  end

  // state registers, first two form the synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      q_ff  <= 1'b0;
      dq_ff <= 1'b0;
      pc_ff <= 8'h00;
      mc_ff <= 3'h0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      q_ff  <= nxt_q;
      dq_ff <= q_ff;
      pc_ff <= nxt_pc;
      mc_ff <= nxt_mc;
    end
  end

  assign rise = q_ff & ~dq_ff;
  assign fall = ~q_ff & dq_ff;
endmodule

// >>> logic/pwsm_top.sv
// pwm submodule back end: fine delay, triggers, output control, capture, dma, faults
`timescale 1ns/1ps
`include "pwsm_consts.svh"
// Operation
// - fine delay compare edges in 1/32 clocks
// - three fine delay enables: 1, 2-3, 4-5
// - per compare register trigger enable
// - postscaler limits triggers to last period
// - two muxed trigger outputs, own selects
// - per output polarity inversion
// - mask buffered until force or update
// - cleared enable tristates the output
// - fault drives programmed fault state value
// - capture only when enabled, shared source
// - edge counter source ignores edge type, a none select still blocks
// - one-shot clears capture enable after capture
// - capture flag when count exceeds watermark
// - edge compare used only with counter source
// - filter period and count, zero period bypasses
// - capture dma requests only when enabled
// - write dma request follows reload flag
// - six capture fifos with dma enables
// - eight fault inputs from two channels
// - channel inputs zero are separate pins
// - any mapped active fault disables output
// - automatic or manual fault recovery
module pwsm_top #(
  parameter int DEPTH = 4,
  parameter int CW    = 16
) (
  input  wire logic          MCLK,
  input  wire logic          RESET_N,
  input  wire logic          HSEL,
  input  wire logic [31:0]   HADDR,
  input  wire logic [1:0]    HTRANS,
  input  wire logic          HWRITE,
  input  wire logic [2:0]    HSIZE,
  input  wire logic [31:0]   HWDATA,
  input  wire logic          HREADY,
  output logic      [31:0]   HRDATA,
  output logic               HREADYOUT,
  output logic               HRESP,
  input  wire logic [5:0]    CMP_MATCH,
  input  wire logic [2:0]    PWM_IN,
  input  wire logic [CW-1:0] CNT_VAL,
  input  wire logic          RELOAD_FLAG,
  input  wire logic          LAST_PERIOD,
  input  wire logic          FORCE_OUT,
  input  wire logic [7:0]    FAULT_IN,
  input  wire logic [2:0]    CAP_IN,
  output logic      [2:0]    PWM_O,
  output logic      [2:0]    PWM_OE,
  output pwsm_pkg::pwsm_fdly_t FDLY,
  output logic      [5:0]    TRIG_OUT,
  output logic      [1:0]    MUX_TRIG,
  output logic               DMA_WREQ,
  output logic      [5:0]    DMA_RREQ
);
  import pwsm_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int NW = $clog2(DEPTH + 1);

  // capture control word decode
  function automatic pwsm_capcfg_t cap_dec(input logic [31:0] w);
    pwsm_capcfg_t c;
    c.en      = w[`PWSM_EN_BIT];
    c.src     = w[`PWSM_SRC_BIT];
    c.esel[0] = pwsm_edge_t'(w[`PWSM_ESEL_LSB +: 2]);
    c.esel[1] = pwsm_edge_t'(w[`PWSM_ESEL_LSB + 2 +: 2]);
    c.oneshot = w[`PWSM_OS_BIT];
    c.wm      = w[`PWSM_WM_LSB +: 2];
    c.fcnt    = w[`PWSM_FCNT_LSB +: 3];
    c.ecmp    = w[`PWSM_ECMP_LSB +: 8];
    c.fper    = w[`PWSM_FPER_LSB +: 8];
    return c;
  endfunction

  // trigger mux: 0..5 gated triggers, 6 first channel, 7 second channel
  function automatic logic tmux(input logic [2:0] s, input logic [5:0] t,
                                input logic pa, input logic pb);
    logic r;
    r = (s == 3'h6) ? pa : (s == 3'h7) ? pb : t[s];
    return r;
  endfunction

  // ************************************************************
  // bus slave
  // ************************************************************
  logic        acc;
  logic        wr_ff, nxt_wr;
  logic [7:0]  wadr_ff, nxt_wadr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] fraca_ff, fracb_ff, trig_ff, outc_ff, dma_ff, fmap_ff;
  logic [31:0] nxt_fraca, nxt_fracb, nxt_trig, nxt_outc, nxt_dma, nxt_fmap;
  logic [31:0] capw [3];
  logic [CW-1:0] head_w [6];
  logic [5:0]  cf_w, ne_w, popv;
  logic [7:0]  fpin_ff, fflag_ff;

  assign acc = HSEL & HREADY & HTRANS[1];

  // address phase capture and read data
  always_comb begin
    nxt_wr    = acc & HWRITE;
    nxt_wadr  = acc ? HADDR[7:0] : wadr_ff;
    nxt_rdata = rdata_ff;
    popv      = 6'h00;
    if (acc && !HWRITE) begin
      nxt_rdata = 32'h0000_0000;
      case (HADDR[7:0])
        `PWSM_OFS_FRACA: nxt_rdata = fraca_ff;
        `PWSM_OFS_FRACB: nxt_rdata = fracb_ff;
        `PWSM_OFS_TRIG:  nxt_rdata = trig_ff;
        `PWSM_OFS_OUTC:  nxt_rdata = outc_ff;
        `PWSM_OFS_DMA:   nxt_rdata = dma_ff;
        `PWSM_OFS_FMAP:  nxt_rdata = fmap_ff;
        `PWSM_OFS_STS: begin
          nxt_rdata[0]                     = RELOAD_FLAG;
          nxt_rdata[`PWSM_CF_LSB +: 6]     = cf_w;
          nxt_rdata[`PWSM_FFLG_LSB +: 8]   = fflag_ff;
          nxt_rdata[`PWSM_FPIN_LSB +: 8]   = fpin_ff;
        end
        default: nxt_rdata = 32'h0000_0000;
      endcase
      for (int p = 0; p < 3; p++) begin
        if (HADDR[7:0] == `PWSM_OFS_CAP + 8'(4 * p)) begin
          nxt_rdata = capw[p];
        end
      end
      // reading a fifo word pops it
      for (int k = 0; k < 6; k++) begin
        if (HADDR[7:0] == `PWSM_OFS_FIFO + 8'(4 * k)) begin
          nxt_rdata = 32'(head_w[k]);
          popv[k]   = ne_w[k];
        end
      end
    end
  end

  // register writes land in the data phase
  always_comb begin
    nxt_fraca = fraca_ff;
    nxt_fracb = fracb_ff;
    nxt_trig  = trig_ff;
    nxt_outc  = outc_ff;
    nxt_dma   = dma_ff;
    nxt_fmap  = fmap_ff;
    if (wr_ff) begin
      case (wadr_ff)
        `PWSM_OFS_FRACA: nxt_fraca = HWDATA;
        `PWSM_OFS_FRACB: nxt_fracb = HWDATA;
        `PWSM_OFS_TRIG:  nxt_trig  = HWDATA;
        `PWSM_OFS_OUTC: begin
          nxt_outc = HWDATA;
          nxt_outc[`PWSM_SWUP_BIT] = 1'b0; // update command is a pulse
        end
        `PWSM_OFS_DMA:   nxt_dma   = HWDATA;
        `PWSM_OFS_FMAP:  nxt_fmap  = HWDATA;
        default:         nxt_fraca = fraca_ff;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_ff     <= 1'b0;
      wadr_ff   <= 8'h00;
      rdata_ff  <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      fraca_ff  <= `PWSM_RST_WORD;
      fracb_ff  <= `PWSM_RST_WORD;
      trig_ff   <= `PWSM_RST_WORD;
      outc_ff   <= `PWSM_RST_WORD;
      dma_ff    <= `PWSM_RST_WORD;
      fmap_ff   <= `PWSM_RST_WORD;
    end else begin
      wr_ff     <= nxt_wr;
      wadr_ff   <= nxt_wadr;
      rdata_ff  <= nxt_rdata;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      fraca_ff  <= nxt_fraca;
      fracb_ff  <= nxt_fracb;
      trig_ff   <= nxt_trig;
      outc_ff   <= nxt_outc;
      dma_ff    <= nxt_dma;
      fmap_ff   <= nxt_fmap;
    end
  end

  assign HRDATA = rdata_ff;

  // ************************************************************
  // faults
  // ************************************************************
  logic [7:0] fsync_ff, nxt_fflag, factive;
  logic [2:0] fdis;

  // latched flags: pin set wins over write-one clear
  always_comb begin
    nxt_fflag = fflag_ff;
    if (wr_ff && wadr_ff == `PWSM_OFS_STS) begin
      nxt_fflag = fflag_ff & ~HWDATA[`PWSM_FFLG_LSB +: 8];
    end
    nxt_fflag = nxt_fflag | fpin_ff;
    // bits 3..0 from channel zero, 7..4 from channel one, each its own pin
    if (fmap_ff[`PWSM_AUTO_BIT]) begin
      factive = fpin_ff;
    end else begin
      factive = fflag_ff | (fmap_ff[`PWSM_SAFE_BIT] ? fpin_ff : 8'h00);
    end
    for (int o = 0; o < 3; o++) begin
      fdis[o] = |(fmap_ff[8 * o +: 8] & factive);
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fsync_ff <= 8'h00;
      fpin_ff  <= 8'h00;
      fflag_ff <= 8'h00;
    end else begin
      fsync_ff <= FAULT_IN;
      fpin_ff  <= fsync_ff;
      fflag_ff <= nxt_fflag;
    end
  end

  // ************************************************************
  // triggers, fine delay and output path
  // ************************************************************
  logic [5:0] trg;
  logic [1:0] nxt_mux;
  logic [2:0] mask_ff, nxt_mask, nxt_o, nxt_oe, src;
  logic       swup;
  pwsm_fdly_t fd_ff, nxt_fd;
  logic [4:0] f1, f2, f3, f4, f5;

  always_comb begin
    trg = CMP_MATCH & trig_ff[5:0];
    if (trig_ff[`PWSM_PS_BIT] && !LAST_PERIOD) begin
      trg = 6'h00;
    end
    nxt_mux[0] = tmux(trig_ff[`PWSM_MUX0_LSB +: 3], trg, PWM_O[1], PWM_O[2]);
    nxt_mux[1] = tmux(trig_ff[`PWSM_MUX1_LSB +: 3], trg, PWM_O[1], PWM_O[2]);
  end

  // fine delay codes follow the compare edge that moved each output
  always_comb begin
    f1 = fracb_ff[`PWSM_FE1_BIT]  ? fraca_ff[`PWSM_F1_LSB +: 5] : 5'h00;
    f2 = fracb_ff[`PWSM_FE23_BIT] ? fraca_ff[`PWSM_F2_LSB +: 5] : 5'h00;
    f3 = fracb_ff[`PWSM_FE23_BIT] ? fraca_ff[`PWSM_F3_LSB +: 5] : 5'h00;
    f4 = fracb_ff[`PWSM_FE45_BIT] ? fraca_ff[`PWSM_F4_LSB +: 5] : 5'h00;
    f5 = fracb_ff[`PWSM_FE45_BIT] ? fracb_ff[`PWSM_F5_LSB +: 5] : 5'h00;
    nxt_fd = fd_ff;
    if (CMP_MATCH[0]) nxt_fd.x = 5'h00;
    if (CMP_MATCH[1]) nxt_fd.x = f1;
    if (CMP_MATCH[2]) nxt_fd.a = f2;
    if (CMP_MATCH[3]) nxt_fd.a = f3;
    if (CMP_MATCH[4]) nxt_fd.b = f4;
    if (CMP_MATCH[5]) nxt_fd.b = f5;
  end

  // select, invert, mask, fault override, enable
  always_comb begin
    swup     = wr_ff && wadr_ff == `PWSM_OFS_OUTC && HWDATA[`PWSM_SWUP_BIT];
    nxt_mask = mask_ff;
    if (swup) begin
      nxt_mask = HWDATA[`PWSM_MASK_LSB +: 3];
    end else if (FORCE_OUT) begin
      nxt_mask = outc_ff[`PWSM_MASK_LSB +: 3];
    end
    src    = PWM_IN;
    src[0] = outc_ff[`PWSM_XSRC_BIT] ? MUX_TRIG[0] : PWM_IN[0];
    for (int o = 0; o < 3; o++) begin
      nxt_o[o] = src[o] ^ outc_ff[`PWSM_INV_LSB + o];
      if (mask_ff[o]) nxt_o[o] = 1'b0;
      if (fdis[o]) nxt_o[o] = outc_ff[`PWSM_FST_LSB + o];
      nxt_oe[o] = outc_ff[`PWSM_OEN_LSB + o];
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mask_ff  <= 3'h0;
      fd_ff    <= '0;
      TRIG_OUT <= 6'h00;
      MUX_TRIG <= 2'h0;
      PWM_O    <= 3'h0;
      PWM_OE   <= 3'h0;
    end else begin
      mask_ff  <= nxt_mask;
      fd_ff    <= nxt_fd;
      TRIG_OUT <= trg;
      MUX_TRIG <= nxt_mux;
      PWM_O    <= nxt_o;
      PWM_OE   <= nxt_oe;
    end
  end

  assign FDLY = fd_ff;

  // ************************************************************
  // capture and fifos
  // ************************************************************
  for (genvar p = 0; p < 3; p++) begin : g_cap
    logic [31:0]  cfg_ff, nxt_cfg;
    logic [7:0]   ecnt_ff, nxt_ecnt;
    logic [1:0]   ev;
    logic         rise, fall, ehit;
    pwsm_capcfg_t cf;

    assign cf      = cap_dec(cfg_ff);
    assign capw[p] = cfg_ff;

    pwsm_filt u_filt (
      .clk   (MCLK),
      .rst_n (RESET_N),
      .din   (CAP_IN[p]),
      .per   (cf.fper),
      .cnt   (cf.fcnt),
      .rise  (rise),
      .fall  (fall)
    );

    // edge counter, capture events and one-shot clear
    always_comb begin
      ehit     = 1'b0;
      nxt_ecnt = ecnt_ff;
      if (cf.en && cf.src && (rise || fall)) begin
        if (ecnt_ff + 8'h01 >= cf.ecmp) begin
          ehit     = 1'b1;
          nxt_ecnt = 8'h00;
        end else begin
          nxt_ecnt = ecnt_ff + 8'h01;
        end
      end
      for (int c = 0; c < 2; c++) begin
        ev[c] = cf.en && cf.esel[c] != EDGE_NONE &&
                (cf.src ? ehit : ((cf.esel[c][0] & fall) | (cf.esel[c][1] & rise)));
      end
      nxt_cfg = cfg_ff;
      if (cf.oneshot && |ev) nxt_cfg[`PWSM_EN_BIT] = 1'b0;
      if (wr_ff && wadr_ff == `PWSM_OFS_CAP + 8'(4 * p)) nxt_cfg = HWDATA;
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
        cfg_ff  <= `PWSM_RST_WORD;
        ecnt_ff <= 8'h00;
      end else begin
        cfg_ff  <= nxt_cfg;
        ecnt_ff <= nxt_ecnt;
      end
    end

    for (genvar c = 0; c < 2; c++) begin : g_fifo
      localparam int K = 2 * p + c;
      logic [CW-1:0] mem_ff [DEPTH];
      logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
      logic [NW-1:0] n_ff, nxt_n;
      logic          push, pop;

      // full fifo drops new captures
      always_comb begin
        push   = ev[c] && n_ff != NW'(DEPTH);
        pop    = popv[K];
        nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
        nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
        nxt_n  = n_ff + NW'(push) - NW'(pop);
      end

      always_ff @(posedge MCLK) begin
        if (push) mem_ff[wp_ff] <= CNT_VAL;
      end

      always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
          wp_ff <= '0;
          rp_ff <= '0;
          n_ff  <= '0;
        end else begin
          wp_ff <= nxt_wp;
          rp_ff <= nxt_rp;
          n_ff  <= nxt_n;
        end
      end

      assign head_w[K] = mem_ff[rp_ff];
      assign ne_w[K]   = n_ff != '0;
      assign cf_w[K]   = n_ff > NW'(cf.wm);
    end
  end

  // ************************************************************
  // dma requests
  // ************************************************************
  logic [5:0] nxt_rreq;

  always_comb begin
    nxt_rreq = 6'h00;
    if (dma_ff[`PWSM_CDMA_BIT]) begin
      nxt_rreq = dma_ff[`PWSM_RDMA_LSB +: 6] &
                 (dma_ff[`PWSM_CSRC_BIT] ? ne_w : cf_w);
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DMA_WREQ <= 1'b0;
      DMA_RREQ <= 6'h00;
    end else begin
      DMA_WREQ <= dma_ff[`PWSM_WDMA_BIT] & RELOAD_FLAG;
      DMA_RREQ <= nxt_rreq;
    end
  end
endmodule

// >>> tb/pwsm_checker.sv
// assertion checker on the pwm submodule back end ports
`timescale 1ns/1ps
`include "pwsm_consts.svh"
module pwsm_checker (
  input wire logic        MCLK,
  input wire logic        RESET_N,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic [5:0]  CMP_MATCH,
  input wire logic        RELOAD_FLAG,
  input wire logic [2:0]  PWM_OE,
  input wire logic [5:0]  TRIG_OUT,
  input wire logic        DMA_WREQ,
  input wire logic [5:0]  DMA_RREQ
);
  logic       rd_take;
  logic       wr_take;
  logic [3:0] bus_age_ff;
  logic [3:0] nxt_bus_age;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  // transfers taken by the slave
  assign wr_take = HSEL && HREADY && HTRANS[1] && HWRITE;
  assign rd_take = HSEL && HREADY && HTRANS[1] && !HWRITE;

  // cycles since the last bus transfer, saturating
  always_comb begin
    nxt_bus_age = (bus_age_ff == 4'hf) ? bus_age_ff : bus_age_ff + 4'h1;
    if (wr_take || rd_take) begin
      nxt_bus_age = 4'h0;
    end
  end

  // age register
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bus_age_ff <= 4'h0;
    end else begin
      bus_age_ff <= nxt_bus_age;
    end
  end

  // status read returns the reload flag level
  property rd_taken_sts;
    rd_take && HADDR[7:0] == `PWSM_OFS_STS && $stable(RELOAD_FLAG)
      |=> HRDATA[0] == $past(RELOAD_FLAG);
  endproperty

  ready_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready or not okay");
  rdata_hold_a: assert property (!rd_take |=> $stable(HRDATA))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (rd_take && HADDR[7:0] > 8'h3c |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  trig_cause_a: assert property ((TRIG_OUT & ~$past(CMP_MATCH)) == 6'h00)
    else $error("trigger without compare match");
  wdma_cause_a: assert property (DMA_WREQ |-> $past(RELOAD_FLAG))
    else $error("write dma request without reload flag");
  sts_reload_a: assert property (rd_taken_sts)
    else $error("status reload bit wrong");
  oe_cause_a: assert property ($changed(PWM_OE) |-> $past(wr_take, 2) || $past(wr_take, 3))
    else $error("output enable moved without a write");
  rreq_fall_a: assert property (($past(DMA_RREQ) & ~DMA_RREQ) != 6'h00 |-> bus_age_ff <= 4'h6)
    else $error("read dma request dropped without bus access");

  // main scenarios reached
  cover property (TRIG_OUT != 6'h00);
  cover property (DMA_WREQ);
  cover property (DMA_RREQ != 6'h00);
endmodule

bind pwsm_top pwsm_checker u_chk (
  .MCLK, .RESET_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT,
  .HRESP, .CMP_MATCH, .RELOAD_FLAG, .PWM_OE, .TRIG_OUT, .DMA_WREQ, .DMA_RREQ
);

// >>> tb/pwsm_stage.sv
// far side model: power switch pins and capture signal sources
`timescale 1ns/1ps
module pwsm_stage (
  input  wire logic       clk,
  input  wire logic [2:0] drv,
  input  wire logic [2:0] drv_en,
  output logic      [2:0] pin,
  output logic      [2:0] cap
);
  // a released pin shows the inverse of the present drv level, never a stale copy
  assign pin = (drv & drv_en) | (~drv & ~drv_en);

  // sources idle low
  initial begin
    cap = 3'h0;
  end

  // one pulse on a capture source, high and low for wd cycles each
  task automatic pulse(input int ch, input int wd);
    cap[ch] <= 1'b1;
    repeat (wd) @(posedge clk);
    cap[ch] <= 1'b0;
    repeat (wd) @(posedge clk);
  endtask
endmodule

// >>> tb/pwsm_top_bench.sv
// self-checking bench for the pwm submodule back end
`timescale 1ns/1ps
`include "pwsm_consts.svh"
module pwsm_top_bench;
  import pwsm_pkg::*;
  logic        mclk, reset_n, hsel, hwrite, reload, last_per, force_out;
  logic        hreadyout, hresp, wreq;
  logic [1:0]  htrans, mux_trig;
  logic [2:0]  pwm_in, cap_in, pwm_o, pwm_oe, pin;
  logic [5:0]  cmp_match, trig_out, rreq;
  logic [7:0]  fault_in;
  logic [15:0] cnt_val;
  logic [31:0] haddr, hwdata, hrdata;
  pwsm_fdly_t  fdly;
  int          n_fail, n_checks;

  pwsm_top DUT (
    .MCLK(mclk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .CMP_MATCH(cmp_match), .PWM_IN(pwm_in),
    .CNT_VAL(cnt_val), .RELOAD_FLAG(reload), .LAST_PERIOD(last_per), .FORCE_OUT(force_out),
    .FAULT_IN(fault_in), .CAP_IN(cap_in), .PWM_O(pwm_o), .PWM_OE(pwm_oe), .FDLY(fdly),
    .TRIG_OUT(trig_out), .MUX_TRIG(mux_trig), .DMA_WREQ(wreq), .DMA_RREQ(rreq)
  );
  pwsm_stage u_stg (.clk(mclk), .drv(pwm_o), .drv_en(pwm_oe), .pin(pin), .cap(cap_in));

  // clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // **********************************************
  // verdict, compare and bus tasks
  // **********************************************
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // wait for hready sampled high, bounded
  task automatic hs();
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    hs();
    htrans <= 2'h0;
    hwdata <= d;
    hs();
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    hs();
    htrans <= 2'h0;
    hs();
    chk(hrdata, e);
  endtask

  // **********************************************
  // main sequence
  // **********************************************
  initial begin
    {reset_n, hsel, hwrite, reload, last_per, force_out, htrans} = '0;
    {pwm_in, cmp_match, fault_in, haddr, hwdata} = '0;
    cnt_val = 16'h1234;
    n_fail = 0;
    n_checks = 0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    // reset values, unmapped place
    for (int a = 0; a <= 'h24; a += 4) rc(8'(a), `PWSM_RST_WORD);
    rc(8'h40, 32'h0);
    chk(32'(pwm_oe), 32'h0);
    wr(`PWSM_OFS_FRACA, 32'h1f0a_1501);
    rc(`PWSM_OFS_FRACA, 32'h1f0a_1501);
    wr(`PWSM_OFS_FRACB, 32'h0000_0713);
    rc(`PWSM_OFS_FRACB, 32'h0000_0713);
    // fine delay code follows the matching compare register
    cmp_match <= 6'h16;
    w(2);
    chk(32'(fdly), 32'({5'h01, 5'h15, 5'h1f}));
    cmp_match <= 6'h29;
    w(2);
    chk(32'(fdly), 32'({5'h00, 5'h0a, 5'h13}));
    cmp_match <= 6'h04;
    wr(`PWSM_OFS_FRACB, 32'h0000_0513);
    w(2);
    chk(32'(fdly), 32'({5'h00, 5'h00, 5'h13}));
    cmp_match <= 6'h00;
    // inversion, mask buffering, enable
    pwm_in <= 3'h5;
    wr(`PWSM_OFS_OUTC, 32'h0000_0702);
    w(4);
    chk(32'(pwm_o), 32'h7);
    chk(32'(pin), 32'h7);
    wr(`PWSM_OFS_OUTC, 32'h0000_0712);
    w(4);
    chk(32'(pwm_o), 32'h7);
    force_out <= 1'b1;
    w(1);
    force_out <= 1'b0;
    w(4);
    chk(32'(pwm_o), 32'h6);
    wr(`PWSM_OFS_OUTC, 32'h0001_0602);
    w(4);
    chk(32'(pwm_o), 32'h7);
    chk(32'(pwm_oe), 32'h6);
    chk(32'(pin), 32'h6);
    // faults: channel one input zero mapped to the aux output
    pwm_in <= 3'h0;
    wr(`PWSM_OFS_OUTC, 32'h0000_1702);
    wr(`PWSM_OFS_FMAP, 32'h0100_0010);
    fault_in <= 8'h01;
    w(8);
    chk(32'(pwm_o), 32'h2);
    fault_in <= 8'h10;
    w(8);
    chk(32'(pwm_o), 32'h3);
    rc(`PWSM_OFS_STS, 32'h0010_1100);
    fault_in <= 8'h00;
    w(8);
    chk(32'(pwm_o), 32'h2);
    wr(`PWSM_OFS_STS, 32'h0000_1100);
    wr(`PWSM_OFS_FMAP, 32'h0000_0010);
    fault_in <= 8'h10;
    w(8);
    fault_in <= 8'h00;
    w(8);
    chk(32'(pwm_o), 32'h3);
    wr(`PWSM_OFS_STS, 32'h0000_1100);
    w(6);
    chk(32'(pwm_o), 32'h2);
    // triggers, postscaler, muxed outputs
    wr(`PWSM_OFS_TRIG, 32'h0000_003f);
    cmp_match <= 6'h21;
    w(3);
    chk(32'(trig_out), 32'h21);
    wr(`PWSM_OFS_TRIG, 32'h0060_0101);
    cmp_match <= 6'h3f;
    w(4);
    chk(32'(trig_out), 32'h0);
    last_per <= 1'b1;
    w(4);
    chk(32'(trig_out), 32'h01);
    chk(32'(mux_trig), 32'h3);
    wr(`PWSM_OFS_OUTC, 32'h0004_0702);
    w(2);
    chk(32'(pwm_o), 32'h3);
    cmp_match <= 6'h00;
    w(4);
    chk(32'(mux_trig), 32'h2);
    chk(32'(pwm_o), 32'h2);
    // write dma follows the reload flag
    wr(`PWSM_OFS_DMA, 32'h0000_0001);
    reload <= 1'b1;
    w(3);
    chk(32'(wreq), 32'h1);
    rc(`PWSM_OFS_STS, 32'h0000_0001);
    wr(`PWSM_OFS_DMA, 32'h0000_0000);
    w(3);
    chk(32'(wreq), 32'h0);
    reload <= 1'b0;
    // capture on both circuits, flags, read dma, pops
    wr(`PWSM_OFS_CAP, 32'h0000_0019);
    u_stg.pulse(0, 4);
    w(16);
    rc(`PWSM_OFS_STS, 32'h0000_0006);
    wr(`PWSM_OFS_DMA, 32'h0000_0032);
    w(4);
    chk(32'(rreq), 32'h03);
    wr(`PWSM_OFS_CAP, 32'h0000_0119);
    rc(`PWSM_OFS_STS, 32'h0000_0000);
    wr(`PWSM_OFS_DMA, 32'h0000_0036);
    w(4);
    chk(32'(rreq), 32'h03);
    wr(`PWSM_OFS_CAP, 32'h0000_0019);
    wr(`PWSM_OFS_DMA, 32'h0000_0030);
    w(4);
    chk(32'(rreq), 32'h00);
    rc(`PWSM_OFS_FIFO, 32'h0000_1234);
    rc(`PWSM_OFS_STS, 32'h0000_0004);
    rc(`PWSM_OFS_FIFO + 8'h04, 32'h0000_1234);
    // disabled capture, then one-shot
    wr(`PWSM_OFS_CAP, 32'h0000_0018);
    u_stg.pulse(0, 4);
    w(16);
    rc(`PWSM_OFS_STS, 32'h0000_0000);
    wr(`PWSM_OFS_CAP, 32'h0000_0049);
    u_stg.pulse(0, 4);
    w(16);
    rc(`PWSM_OFS_CAP, 32'h0000_0048);
    rc(`PWSM_OFS_FIFO, 32'h0000_1234);
    // filter drops a glitch, passes a long pulse
    wr(`PWSM_OFS_CAP, 32'h0200_3009);
    u_stg.pulse(0, 2);
    w(24);
    rc(`PWSM_OFS_STS, 32'h0000_0000);
    u_stg.pulse(0, 12);
    w(24);
    rc(`PWSM_OFS_STS, 32'h0000_0002);
    rc(`PWSM_OFS_FIFO, 32'h0000_1234);
    // edge counter source, fall select ignored, four edges
    wr(`PWSM_OFS_CAP, 32'h0004_0007);
    u_stg.pulse(0, 4);
    w(16);
    rc(`PWSM_OFS_STS, 32'h0000_0000);
    u_stg.pulse(0, 4);
    w(16);
    rc(`PWSM_OFS_STS, 32'h0000_0002);
    conclude();
  end
endmodule
